/* File: hw/tmc_timer_counter.sv */
// 8-bit timer/counter with shared prescaler and external count synchroniser
//
// Overview of operation
// R01: Count register is 8 bits, read and write.
// R02: Source bit clear counts instruction cycles.
// R03: Write to count inhibits next two cycles.
// R04: Source bit set counts external pin edges.
// R05: Edge bit: zero rising, one falling.
// R06: Prescaler serves timer or watchdog, assign-bit zero timer.
// R07: Prescaler count has no software access.
// R08: Prescaler ratios 1:2 through 1:256.
// R09: Prescaler output sampled on second and fourth phase.
// R10: Source holds pin two oscillator periods each level.
// R11: Prescaler output is symmetric divided input.
// R12: Prescaled source period at least four periods over ratio.
// R13: Synchronisation delays increment, error four periods max.
// R14: Instruction cycle is four oscillator phases.
// R15: Count wraps from all ones to zero.
`timescale 1ns/10ps
module tmc_timer_counter import tmc_pkg::*; (
  // Clock, reset and enable
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic ce,
  // Register port
  input wire tmc_bus_req_type bus_req,
  output logic [DATA_W-1:0] rd_data,
  // External count pin
  input wire logic external_count_input,
  // Prescaler tick handed to the watchdog counter
  output logic watchdog_tick,
  // Count observation
  output logic [DATA_W-1:0] count_out,
  output logic count_wrap
);

  ////////////////////////////////////////////////////////////////////////////
  // Registers and decode

  tmc_option_type option;
  logic [DATA_W-1:0] timer_count_value;
  logic [1:0] inhibit;
  logic wrap_flag;
  tmc_phase_type phase;
  tmc_phase_type next_phase;

  logic wr_count;
  logic wr_option;
  logic wr_status;

  assign wr_count = bus_req.wr && (bus_req.addr == OFS_COUNT);
  assign wr_option = bus_req.wr && (bus_req.addr == OFS_OPTION);
  assign wr_status = bus_req.wr && (bus_req.addr == OFS_STATUS);

  ////////////////////////////////////////////////////////////////////////////
  // Phase generator

  always_comb begin
    case (phase)
      PH_FIRST: next_phase = PH_SECOND;
      PH_SECOND: next_phase = PH_THIRD;
      PH_THIRD: next_phase = PH_FOURTH;
      PH_FOURTH: next_phase = PH_FIRST;
      default: next_phase = PH_FIRST;
    endcase
  end

  // Four oscillator periods form one instruction cycle
  always_ff @(posedge ref_clk or negedge rst_n) begin // R14
    if (!rst_n) begin
      phase <= PH_FIRST;
    end else if (ce) begin
      phase <= next_phase;
    end
  end

  logic instr_tick;
  logic sample_phase;

  assign instr_tick = (phase == PH_FOURTH);
  assign sample_phase = (phase == PH_SECOND) || (phase == PH_FOURTH); // R09

  ////////////////////////////////////////////////////////////////////////////
  // Option control

  logic assign_change;

  // Moving the prescaler between owners restarts it so neither sees a stale count
  assign assign_change = wr_option && (bus_req.wdata[OPT_ASSIGN_BIT] != option.prescaler_assign);

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      option <= tmc_option_type'(OPTION_RESET);
    end else if (ce && wr_option) begin
      option <= tmc_option_type'(bus_req.wdata);
      // Reserved bits never keep a written one, so they always read back as zero
      option.reserved <= 2'h0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // External pin edge select

  logic pin_q;
  logic pin_prev;
  logic pin_pol;
  logic pin_pol_prev;
  logic pin_edge;

  // The pin is synchronous to ref_clk; one register gives the edge detector a stable view
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      pin_q <= 1'b0;
      pin_prev <= 1'b0;
    end else if (ce) begin
      pin_q <= external_count_input;
      pin_prev <= pin_q;
    end
  end

  // Inverting the pin turns a falling edge into the rising edge that is counted
  // Limitation: changing the edge bit while the pin rests is itself an edge and may add a count
  assign pin_pol = pin_q ^ option.source_edge_select; // R05
  assign pin_pol_prev = pin_prev ^ option.source_edge_select; // R05
  assign pin_edge = rise(pin_pol, pin_pol_prev);

  ////////////////////////////////////////////////////////////////////////////
  // Prescaler

  logic pre_en;
  logic pre_tap;
  logic tap_prev;
  logic tap_rise;

  // Counter mode with the prescaler feeds pin edges, otherwise instruction cycles
  assign pre_en = (option.clock_source_select && !option.prescaler_assign) ? pin_edge : instr_tick; // R04

  // Only the ratio, owner, source and edge bits reach it; no register path exposes its count
  tmc_prescaler #(
    .WIDTH(DATA_W)
  ) u_prescaler (
    .ref_clk(ref_clk),
    .rst_n(rst_n),
    .ce(ce),
    .clear(assign_change),
    .count_en(pre_en),
    .ratio(option.ratio),
    .tap(pre_tap)
  ); // R07

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      tap_prev <= 1'b0;
    end else if (ce) begin
      tap_prev <= pre_tap;
    end
  end

  assign tap_rise = rise(pre_tap, tap_prev);

  // Owner bit set hands the prescaler to the watchdog and takes it from the timer
  always_ff @(posedge ref_clk or negedge rst_n) begin // R06
    if (!rst_n) begin
      watchdog_tick <= 1'b0;
    end else if (ce) begin
      watchdog_tick <= option.prescaler_assign && tap_rise;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Synchroniser on the second and fourth phases

  logic sync_src;
  logic sync_sample;
  logic ext_step;

  // Without the prescaler the pin is the prescaler output
  assign sync_src = option.prescaler_assign ? pin_pol : pre_tap; // R09

  // Two samples per instruction cycle: a level shorter than two periods may be missed,
  // which is why the source must hold each level that long
  always_ff @(posedge ref_clk or negedge rst_n) begin // R09
    if (!rst_n) begin
      // An idle low pin under the reset option word samples as one, so no count follows reset
      sync_sample <= OPTION_RESET[OPT_SE_BIT];
      ext_step <= 1'b0;
    end else if (ce) begin
      ext_step <= 1'b0;
      if (sample_phase) begin
        sync_sample <= sync_src;
        ext_step <= rise(sync_src, sync_sample); // R13
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Count source and write inhibit

  logic timer_step;
  logic step;

  // Timer mode: every instruction cycle, or every prescaler tap rise
  assign timer_step = option.prescaler_assign ? instr_tick : tap_rise; // R02
  assign step = option.clock_source_select ? ext_step : timer_step; // R04

  // Counted in instruction cycles, so a write mid-cycle loses the rest of it as well
  always_ff @(posedge ref_clk or negedge rst_n) begin // R03
    if (!rst_n) begin
      inhibit <= INHIBIT_RESET;
    end else if (ce) begin
      if (wr_count) begin
        inhibit <= 2'(WRITE_INHIBIT_CYCLES);
      end else if (instr_tick && inhibit != 2'h0) begin
        inhibit <= inhibit - 2'h1;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Timer/counter register

  // One helper for the register and its mirror, so both wrap identically
  function automatic logic [DATA_W-1:0] incr(input logic [DATA_W-1:0] v);
    return v + DATA_W'(1);
  endfunction

  logic do_inc;

  assign do_inc = step && (inhibit == 2'h0) && !wr_count; // R03

  always_ff @(posedge ref_clk or negedge rst_n) begin // R01
    if (!rst_n) begin
      timer_count_value <= COUNT_RESET;
    end else if (ce) begin
      if (wr_count) begin
        timer_count_value <= bus_req.wdata;
      end else if (do_inc) begin
        timer_count_value <= incr(timer_count_value); // R15
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Wrap flag and outputs

  logic wrap_event;

  assign wrap_event = do_inc && (timer_count_value == 8'hFF); // R15

  // Set wins over a clear in the same cycle
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      wrap_flag <= 1'b0;
    end else if (ce) begin
      if (wrap_event) begin
        wrap_flag <= 1'b1;
      end else if (wr_status && bus_req.wdata[ST_WRAP_BIT]) begin
        wrap_flag <= 1'b0;
      end
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      count_out <= COUNT_RESET;
      count_wrap <= 1'b0;
    end else if (ce) begin
      // Same next value as the register, so the mirror never drifts from it
      count_out <= wr_count ? bus_req.wdata : (do_inc ? incr(timer_count_value) : timer_count_value);
      count_wrap <= wrap_event;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Read port

  logic [DATA_W-1:0] status_word;

  always_comb begin
    status_word = 8'h00;
    status_word[ST_WRAP_BIT] = wrap_flag;
    status_word[ST_INHIBIT_BIT] = (inhibit != 2'h0);
    status_word[ST_SAMPLE_BIT] = sync_sample;
    status_word[ST_PHASE_LSB +: 2] = phase;
  end

  // Data stand only in the cycle after the strobe; unmapped reads give zero
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      rd_data <= 8'h00;
    end else if (ce) begin
      rd_data <= 8'h00;
      if (bus_req.rd) begin
        case (bus_req.addr)
          OFS_COUNT: rd_data <= timer_count_value; // R01
          OFS_OPTION: rd_data <= option;
          OFS_STATUS: rd_data <= status_word;
          default: rd_data <= 8'h00;
        endcase
      end
    end
  end

endmodule // tmc_timer_counter

/* File: hw/tmc_pkg.sv */
// Package of constants and carrier types for the 8-bit timer/counter
package tmc_pkg;

  // Clock and timing
  localparam int TOSC_NS = 40;
  localparam int PHASES_PER_CYCLE = 4;
  localparam int INSTR_CYCLE_NS = PHASES_PER_CYCLE * TOSC_NS;
  localparam int EXT_MIN_LEVEL_TOSC = 2;
  localparam int EXT_MIN_PERIOD_PRESCALED_TOSC = 4;
  localparam int WRITE_INHIBIT_CYCLES = 2;

  // Widths
  localparam int DATA_W = 8;
  localparam int ADDR_W = 4;
  localparam int RATIO_W = 3;

  // Register offsets
  localparam logic [ADDR_W-1:0] OFS_COUNT = 4'h0;
  localparam logic [ADDR_W-1:0] OFS_OPTION = 4'h1;
  localparam logic [ADDR_W-1:0] OFS_STATUS = 4'h2;

  // Option control field positions
  localparam int OPT_CS_BIT = 5;
  localparam int OPT_SE_BIT = 4;
  localparam int OPT_ASSIGN_BIT = 3;
  localparam int OPT_RATIO_LSB = 0;

  // Status field positions
  localparam int ST_WRAP_BIT = 0;
  localparam int ST_INHIBIT_BIT = 1;
  localparam int ST_SAMPLE_BIT = 2;
  localparam int ST_PHASE_LSB = 4;

  // Reset values
  localparam logic [DATA_W-1:0] COUNT_RESET = 8'h00;
  localparam logic [DATA_W-1:0] OPTION_RESET = 8'h3F;
  localparam logic [1:0] INHIBIT_RESET = 2'h0;

  // Gray-coded internal phases of one instruction cycle
  typedef enum logic [1:0] {
    PH_FIRST = 2'b00,
    PH_SECOND = 2'b01,
    PH_THIRD = 2'b11,
    PH_FOURTH = 2'b10
  } tmc_phase_type;

  typedef struct packed {
    logic [1:0] reserved;
    logic clock_source_select;
    logic source_edge_select;
    logic prescaler_assign;
    logic [RATIO_W-1:0] ratio;
  } tmc_option_type;

  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
    logic wr;
    logic rd;
  } tmc_bus_req_type;

  function automatic logic rise(input logic cur, input logic prev);
    return cur & ~prev;
  endfunction

endpackage

/* File: hw/tmc_prescaler.sv */
// Shared 8-bit prescaler with power-of-two tap selection
`timescale 1ns/10ps
module tmc_prescaler import tmc_pkg::*; #(
  parameter int WIDTH = 8
) (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic ce,
  // Control
  input wire logic clear,
  input wire logic count_en,
  input wire logic [RATIO_W-1:0] ratio,
  // Selected stage
  output logic tap
);

  logic [WIDTH-1:0] stage;

  // Synchronous equivalent of a ripple chain: each bit is half the rate of the one below,
  // so every tap is a symmetric square wave
  always_ff @(posedge ref_clk or negedge rst_n) begin // R11
    if (!rst_n) begin
      stage <= '0;
    end else if (ce) begin
      if (clear) begin
        stage <= '0;
      end else if (count_en) begin
        stage <= stage + WIDTH'(1);
      end
    end
  end

  // Bit n gives a ratio of 2^(n+1): 1:2 up to 1:256
  assign tap = stage[ratio]; // R08

endmodule // tmc_prescaler

/* File: testbench/tmc_pulse_source.sv */
// Model of the pulse source that drives the count pin
`timescale 1ns/10ps
module tmc_pulse_source (
  // Clock
  input wire logic ref_clk,
  // Count pin, idles low between bursts
  output logic external_count_input
);
  initial begin
    external_count_input = 1'b0;
  end
  // Levels are never shorter than two clocks, so a period never drops under four
  task automatic send(input int n, input int hi, input int lo);
    for (int i = 0; i < n; i++) begin
      @(posedge ref_clk);
      external_count_input <= 1'b1;
      repeat (hi < 2 ? 2 : hi) @(posedge ref_clk);
      external_count_input <= 1'b0;
      repeat (lo < 2 ? 1 : lo - 1) @(posedge ref_clk);
    end
  endtask
  task automatic hold(input logic v);
    @(posedge ref_clk);
    external_count_input <= v;
    repeat (8) @(posedge ref_clk);
    @(negedge ref_clk);
  endtask
endmodule // tmc_pulse_source

/* File: testbench/tmc_timer_counter_assertions.sv */
// Port-level checks for the timer/counter
`timescale 1ns/10ps
module tmc_checker import tmc_pkg::*; (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic ce,
  // Register port
  input wire tmc_bus_req_type bus_req,
  input wire logic [DATA_W-1:0] rd_data,
  // Pin and observation
  input wire logic external_count_input,
  input wire logic watchdog_tick,
  input wire logic [DATA_W-1:0] count_out,
  input wire logic count_wrap
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_n);
  logic [DATA_W-1:0] opt;
  logic [DATA_W-1:0] wval;
  logic [3:0] settle;
  wire logic cwr = ce && bus_req.wr && bus_req.addr == OFS_COUNT;
  wire logic owr = ce && bus_req.wr && bus_req.addr == OFS_OPTION;
  // A frozen cycle is not quiet: nothing may advance while the enable is low
  wire logic quiet = ce && !cwr && !owr;
  wire logic tmode = !opt[OPT_CS_BIT] && opt[OPT_ASSIGN_BIT];
  wire logic cmode = opt[OPT_CS_BIT] && opt[OPT_ASSIGN_BIT];
  ////////////////////////////////////////////////////////////
  // Mode is not visible at the ports, so shadow the option word
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      opt <= OPTION_RESET;
      wval <= COUNT_RESET;
      settle <= 4'h0;
    end else begin
      if (owr) begin
        opt <= bus_req.wdata;
      end
      if (cwr) begin
        wval <= bus_req.wdata;
      end
      // Pending pin samples may still land just after a mode change
      settle <= owr ? 4'h0 : (settle == 4'hF ? settle : settle + 4'h1);
    end
  end
  sequence step_s;
    count_out == $past(count_out) + 8'h01;
  endsequence
  sequence still_s;
    (quiet && $stable(count_out))[*3];
  endsequence
  rd_count_a: assert property (ce && bus_req.rd && bus_req.addr == OFS_COUNT |=> rd_data == $past(count_out))
    else $error("count read mismatch");
  rd_idle_a: assert property (rd_data != 8'h00 |-> $past(bus_req.rd))
    else $error("read data outside read slot");
  wr_count_a: assert property (cwr |=> count_out == wval)
    else $error("count write lost");
  count_step_a: assert property ($changed(count_out) && !$past(cwr) |-> step_s)
    else $error("count moved by other than one");
  inhibit_hold_a: assert property (cwr && tmode |=> (count_out == wval)[*8])
    else $error("count moved during inhibit");
  inhibit_end_a: assert property (cwr && tmode ##1 quiet[*8] |-> ##[1:5] (count_out == wval + 8'h01))
    else $error("count did not resume after inhibit");
  tick_space_a: assert property ($changed(count_out) && tmode && quiet && settle == 4'hF && !$past(cwr) ##1 still_s
    |=> $changed(count_out))
    else $error("timer tick spacing wrong");
  pin_edge_a: assert property (cmode && quiet && (opt[OPT_SE_BIT] ? $fell(external_count_input) :
    $rose(external_count_input)) |-> ##[1:6] $changed(count_out))
    else $error("pin edge not counted in time");
  wd_owner_a: assert property (watchdog_tick |-> opt[OPT_ASSIGN_BIT] || $past(opt[OPT_ASSIGN_BIT]))
    else $error("watchdog tick while prescaler owned by timer");
  wrap_pulse_a: assert property (count_wrap |-> $past(count_out) == 8'hFF && count_out == 8'h00)
    else $error("wrap pulse without wrap");
endmodule // tmc_checker
bind tmc_timer_counter tmc_checker tmc_checker_inst (.ref_clk(ref_clk), .rst_n(rst_n), .ce(ce), .bus_req(bus_req),
  .rd_data(rd_data), .external_count_input(external_count_input), .watchdog_tick(watchdog_tick),
  .count_out(count_out), .count_wrap(count_wrap));

/* File: testbench/tb_tmc_timer_counter.sv */
// Self-checking bench for the timer/counter
`timescale 1ns/10ps
module tb_tmc_timer_counter import tmc_pkg::*; ;
  logic ref_clk = 1'b0;
  logic rst_n = 1'b0;
  tmc_bus_req_type bus_req = '0;
  logic pin;
  logic ce = 1'b1;
  logic [DATA_W-1:0] rd_data;
  logic [DATA_W-1:0] count_out;
  logic watchdog_tick;
  logic count_wrap;
  logic [31:0] seed = 32'h113E31E5;
  int n_mismatch = 0;
  int compares = 0;
  int ticks = 0;
  initial begin
    forever #20 ref_clk = ~ref_clk;
  end
  always @(negedge ref_clk) begin
    if (watchdog_tick === 1'b1) begin
      ticks++;
    end
  end
  tmc_timer_counter tmc_timer_counter_inst (.ref_clk(ref_clk), .rst_n(rst_n), .ce(ce), .bus_req(bus_req),
    .rd_data(rd_data), .external_count_input(pin), .watchdog_tick(watchdog_tick), .count_out(count_out),
    .count_wrap(count_wrap));
  tmc_pulse_source tmc_pulse_source_inst (.ref_clk(ref_clk), .external_count_input(pin));
  ////////////////////////////////////////////////////////////
  function automatic logic [31:0] xs(input logic [31:0] s);
    s ^= s << 13;
    s ^= s >> 17;
    s ^= s << 5;
    return s;
  endfunction
  function automatic logic [DATA_W-1:0] bump(input logic [DATA_W-1:0] v, input int k);
    return v + k[DATA_W-1:0];
  endfunction
  task automatic end_sim();
    if (n_mismatch == 0 && compares > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask
  task automatic check(input logic [DATA_W-1:0] got, input logic [DATA_W-1:0] exp);
    compares++;
    if (got !== exp) begin
      n_mismatch++;
      $display("Error %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic check_range(input int v, input int lo, input int hi);
    compares++;
    if (v < lo || v > hi) begin
      n_mismatch++;
      $display("Error %0t: %0d outside %0d..%0d", $time, v, lo, hi);
    end
  endtask
  // One-cycle strobe, then a released cycle before the next request
  task automatic access(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d, input logic w,
    output logic [DATA_W-1:0] q);
    @(posedge ref_clk);
    bus_req <= '{addr: a, wdata: d, wr: w, rd: !w};
    @(posedge ref_clk);
    bus_req <= '0;
    @(negedge ref_clk);
    q = rd_data;
  endtask
  task automatic wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
    logic [DATA_W-1:0] q;
    access(a, d, 1'b1, q);
  endtask
  task automatic rd(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] exp);
    logic [DATA_W-1:0] q;
    access(a, 8'h00, 1'b0, q);
    check(q, exp);
  endtask
  task automatic wait_change(output int c);
    logic [DATA_W-1:0] v;
    v = count_out;
    c = 0;
    while (count_out === v) begin
      @(negedge ref_clk);
      c++;
      if (c > 2000) begin
        n_mismatch++;
        $display("Error %0t: count stuck", $time);
        end_sim();
      end
    end
  endtask
  ////////////////////////////////////////////////////////////
  initial begin
    logic [DATA_W-1:0] c;
    int t;
    int w;
    repeat (2) @(posedge ref_clk);
    rst_n <= 1'b1;
    rd(OFS_COUNT, COUNT_RESET);
    rd(OFS_OPTION, OPTION_RESET);
    for (int a = 3; a < 16; a++) begin
      rd(a[ADDR_W-1:0], 8'h00);
    end
    // Count and option words read back as written in falling-edge counter mode; reserved option bits read zero
    for (int i = 0; i < 8; i++) begin
      seed = xs(seed);
      wr(OFS_COUNT, seed[7:0]);
      rd(OFS_COUNT, seed[7:0]);
      wr(OFS_OPTION, seed[15:8] | 8'h30);
      rd(OFS_OPTION, (seed[15:8] | 8'h30) & 8'h3F);
    end
    wr(OFS_OPTION, 8'h08);
    seed = xs(seed);
    wr(OFS_COUNT, seed[7:0]);
    wait_change(t);
    check_range(t, 9, 12);
    check(count_out, bump(seed[7:0], 1));
    wait_change(t);
    check_range(t, 4, 4);
    // Enable low must freeze the instruction cycle and with it the count
    @(posedge ref_clk);
    ce <= 1'b0;
    @(negedge ref_clk);
    c = count_out;
    repeat (12) @(negedge ref_clk);
    check(count_out, c);
    @(posedge ref_clk);
    ce <= 1'b1;
    wr(OFS_COUNT, 8'hFE);
    wait_change(t);
    wait_change(t);
    check(count_out, 8'h00);
    check({7'h00, count_wrap}, 8'h01);
    access(OFS_STATUS, 8'h00, 1'b0, c);
    check(c & 8'h03, 8'h01);
    wr(OFS_STATUS, 8'h01);
    access(OFS_STATUS, 8'h00, 1'b0, c);
    check(c & 8'h01, 8'h00);
    wr(OFS_OPTION, 8'h00);
    w = ticks;
    wait_change(t);
    wait_change(t);
    check_range(t, 8, 8);
    check_range(ticks - w, 0, 0);
    wr(OFS_OPTION, 8'h0B);
    w = ticks;
    repeat (200) @(negedge ref_clk);
    check_range(ticks - w, 3, 4);
    for (int e = 0; e < 2; e++) begin
      wr(OFS_OPTION, e ? 8'h38 : 8'h28);
      repeat (8) @(negedge ref_clk);
      c = count_out;
      seed = xs(seed);
      tmc_pulse_source_inst.send(5, 2 + seed[1:0], 2 + seed[3:2]);
      tmc_pulse_source_inst.hold(1'b1);
      check(count_out, bump(c, 6 - e));
      tmc_pulse_source_inst.hold(1'b0);
    end
    for (int n = 0; n < 8; n++) begin
      wr(OFS_OPTION, 8'h08);
      wr(OFS_OPTION, 8'h20 | n[7:0]);
      repeat (8) @(negedge ref_clk);
      c = count_out;
      seed = xs(seed);
      tmc_pulse_source_inst.send(4 << n, 2 + seed[0], 2 + seed[1]);
      repeat (8) @(negedge ref_clk);
      check(count_out, bump(c, 2));
    end
    end_sim();
  end
endmodule // tb_tmc_timer_counter
